// ---- core/celi_cell_event_irq.sv ----
// Purpose: cell transmit/receive event latching and interrupt indication
// Assumes: event inputs are one-cycle pulses from logic on pclk
// Notes: apb slave, one wait-free access phase, registered answer
//   read-clear touches only the bits that the read handed out
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

// Function
// - rx source needs four enables for pin
// - rx enable bits select seven sources
// - rx enables reset to all ones except reserved bit four
// - tx pending bits map five events
// - single event pends on rising status
// - reading pending register clears returned bits
// - rx pending bits map seven events
// - delineation loss pends on both edges
// - parity fault sets tx status bit seven
// - cell start fault sets bit six
// - fifo overruns set bits five and four
// - non-idle cell sent sets bit three
// - tx status latches, read clears the bits it returned
// - delineation status follows present state; no such status is kept here, only its changes pend in rx bit seven
module celi_cell_event_irq
(
  input wire logic pclk,
  input wire logic presetn,
  // apb slave port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit event pulses from the cell transmitter
  input wire logic parity_fault,
  input wire logic cell_start_fault,
  input wire logic tx_fifo_overrun,
  input wire logic rx_fifo_overrun,
  input wire logic cell_out_event,
  // receive level and event pulses from the cell receiver
  input wire logic delin_loss_state,
  input wire logic hdr_err_det,
  input wire logic hdr_err_fix,
  input wire logic cell_in,
  input wire logic idle_in,
  input wire logic screen_reject,
  input wire logic flow_field_set,
  // interrupt outputs, both registered
  output logic host_irq_n,
  output logic irq
);

  // ****************************************************************
  // address decode
  // ****************************************************************
  // match a word address against a register index
  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0] rx_cell_irq_enable; // receive source enables
  logic [7:0] tx_irq_enable; // transmit source enables
  logic [7:0] tx_cell_irq_pending; // transmit indications
  logic [7:0] rx_cell_irq_pending; // receive indications
  logic [7:0] tx_cell_event_status; // latched transmit events
  logic [3:0] irq_gate; // summary, port, pin enables
  logic [1:0] sys_status; // sticky system events
  logic [1:0] sys_mask; // system irq mask
  logic delin_prev; // last delineation state
  logic [7:0] rd_returned; // value handed out at setup

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // transfer phases seen by this slave
  wire setup_ph = psel & ~penable; // first cycle of a transfer
  wire access_done = psel & penable & pready; // transfer completes here
  wire wr_done = access_done & pwrite;
  wire rd_done = access_done & ~pwrite;
  // one select per register; a misaligned address selects nothing
  wire hit_rxen = reg_hit(paddr, celi_pkg::IDX_RX_IRQ_ENABLE);
  wire hit_txen = reg_hit(paddr, celi_pkg::IDX_TX_IRQ_ENABLE);
  wire hit_txp = reg_hit(paddr, celi_pkg::IDX_TX_PENDING);
  wire hit_rxp = reg_hit(paddr, celi_pkg::IDX_RX_PENDING);
  wire hit_txs = reg_hit(paddr, celi_pkg::IDX_TX_STATUS);
  wire hit_gate = reg_hit(paddr, celi_pkg::IDX_IRQ_GATE);
  wire hit_sys = reg_hit(paddr, celi_pkg::IDX_SYS_STATUS);
  wire hit_mask = reg_hit(paddr, celi_pkg::IDX_SYS_MASK);
  wire hit_any = hit_rxen | hit_txen | hit_txp | hit_rxp | hit_txs | hit_gate | hit_sys
    | hit_mask;

  // read mux, sampled into prdata during the setup cycle
  wire [7:0] rd_mux =
    hit_rxen ? rx_cell_irq_enable :
    hit_txen ? tx_irq_enable :
    hit_txp ? tx_cell_irq_pending :
    hit_rxp ? rx_cell_irq_pending :
    hit_txs ? tx_cell_event_status :
    hit_gate ? {4'h0, irq_gate} :
    hit_sys ? {6'h00, sys_status} :
    hit_mask ? {6'h00, sys_mask} : 8'h00;

  // ****************************************************************
  // transmit event latching
  // ****************************************************************
  // events in bit order 7..3; reserved bits never set
  wire [7:0] tx_evt = {parity_fault, cell_start_fault, tx_fifo_overrun, rx_fifo_overrun,
    cell_out_event, 3'h0};
  // a read clears everything it returned, but a same-cycle event still lands
  wire [7:0] tx_stat_clr = (rd_done & hit_txs) ? rd_returned : 8'h00;
  wire [7:0] next_tx_status = (tx_cell_event_status & ~tx_stat_clr) | tx_evt;
  // a pending bit needs the status to go 0 to 1; a cleared-and-set bit counts
  wire [7:0] tx_rise = next_tx_status & ~(tx_cell_event_status & ~tx_stat_clr);
  wire [7:0] tx_set = tx_rise & tx_irq_enable & celi_pkg::TX_USED_MASK;
  // pending clears follow the same returned-bits rule as the status
  wire [7:0] tx_pend_clr = (rd_done & hit_txp) ? rd_returned : 8'h00;
  wire [7:0] next_tx_pending = (tx_cell_irq_pending & ~tx_pend_clr) | tx_set;

  // ****************************************************************
  // receive event latching
  // ****************************************************************
  // delineation flips in either direction; the level itself is not latched
  wire delin_edge = delin_loss_state ^ delin_prev;
  wire [7:0] rx_evt = {delin_edge, hdr_err_det, hdr_err_fix, 1'b0, cell_in, idle_in,
    screen_reject, flow_field_set};
  // disabled sources drop here, so a later enable finds nothing old
  wire [7:0] rx_set = rx_evt & rx_cell_irq_enable & celi_pkg::RX_USED_MASK;
  // a pending bit set in the clearing cycle survives the read
  wire [7:0] rx_pend_clr = (rd_done & hit_rxp) ? rd_returned : 8'h00;
  wire [7:0] next_rx_pending = (rx_cell_irq_pending & ~rx_pend_clr) | rx_set;

  // ****************************************************************
  // interrupt gating
  // ****************************************************************
  // port and pin enables are shared by both cell directions
  wire path_open = irq_gate[celi_pkg::GATE_PORT] & irq_gate[celi_pkg::GATE_PIN];
  wire rx_drive = (|(rx_cell_irq_pending & rx_cell_irq_enable))
    & irq_gate[celi_pkg::GATE_RX_SUM] & path_open;
  wire tx_drive = (|(tx_cell_irq_pending & tx_irq_enable))
    & irq_gate[celi_pkg::GATE_TX_SUM] & path_open;
  // system status records which side raised a pending bit
  wire [1:0] sys_evt = {|rx_set, |tx_set};
  wire [1:0] sys_clr = (wr_done & hit_sys) ? pwdata[1:0] : 2'h0;
  wire [1:0] next_sys_status = (sys_status & ~sys_clr) | sys_evt; // set beats clear

  // ****************************************************************
  // apb answer
  // ****************************************************************
  // ready and data are registered in setup so every access takes two cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // bus answer idle while held in reset
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      rd_returned <= 8'h00;
    end
    else
    begin
      // the snapshot lets the clear match exactly what software saw
      pready <= setup_ph;
      pslverr <= setup_ph & ~hit_any; // unmapped word answers with an error
      prdata <= setup_ph ? {24'h00_0000, rd_mux} : prdata;
      rd_returned <= setup_ph ? rd_mux : rd_returned;
    end
  end

  // ****************************************************************
  // software-written registers
  // ****************************************************************
  // reserved bits are forced to zero so a careless write cannot open them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_cell_irq_enable <= celi_pkg::RST_RX_IRQ_ENABLE;
      tx_irq_enable <= celi_pkg::RST_TX_IRQ_ENABLE;
      irq_gate <= celi_pkg::RST_IRQ_GATE;
      sys_mask <= celi_pkg::RST_SYS_MASK;
    end
    else
    begin
      // receive enables; reserved bit four stays zero
      if (wr_done & hit_rxen)
        rx_cell_irq_enable <= pwdata[7:0] & celi_pkg::RX_USED_MASK;
      // transmit enables; factory and reserved bits stay zero
      if (wr_done & hit_txen)
        tx_irq_enable <= pwdata[7:0] & celi_pkg::TX_USED_MASK;
      // summary, port and pin gating
      if (wr_done & hit_gate)
        irq_gate <= pwdata[3:0];
      // system irq mask
      if (wr_done & hit_mask)
        sys_mask <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // event state and outputs
  // ****************************************************************
  // delin_prev resets to "in delineation"; a loss right after reset pends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // nothing latched, nothing pending, pin released
      tx_cell_event_status <= 8'h00;
      tx_cell_irq_pending <= 8'h00;
      rx_cell_irq_pending <= 8'h00;
      sys_status <= 2'h0;
      delin_prev <= 1'b0;
      host_irq_n <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      // status and pending bits move on the same edge
      tx_cell_event_status <= next_tx_status;
      tx_cell_irq_pending <= next_tx_pending;
      rx_cell_irq_pending <= next_rx_pending;
      sys_status <= next_sys_status;
      delin_prev <= delin_loss_state;
      host_irq_n <= ~(rx_drive | tx_drive);
      irq <= |(sys_status & sys_mask);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // reset leaves every receive source enabled
  a_reset_enables: assert property (@(posedge pclk)
    $rose(presetn) |-> rx_cell_irq_enable == celi_pkg::RST_RX_IRQ_ENABLE)
    else $error("rx enables not at reset value");
  // the reserved enable bit can never be opened by a write
  a_reserved_rx_en: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_cell_irq_enable[4])
    else $error("reserved rx enable bit set");
  // all four enables on: a pending receive source reaches the pin
  a_rx_src_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_cell_irq_pending[3] && rx_cell_irq_enable[3] && irq_gate[celi_pkg::GATE_RX_SUM]
    && path_open) |=> !host_irq_n)
    else $error("enabled rx source not on pin");
  // receive summary off and nothing from transmit: pin stays released
  a_rx_sum_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!irq_gate[celi_pkg::GATE_RX_SUM] && tx_cell_irq_pending == 8'h00) |=> host_irq_n)
    else $error("pin asserted with rx summary off");
  // pin enable off keeps the pin released
  a_pin_needs_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_gate[celi_pkg::GATE_PIN] |=> host_irq_n)
    else $error("pin asserted with pin enable off");
  // nothing pending anywhere: the pin lets go one cycle later
  a_pin_release: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_cell_irq_pending == 8'h00 && tx_cell_irq_pending == 8'h00) |=> host_irq_n)
    else $error("pin held with nothing pending");

  // parity fault lands in status bit seven
  a_tx_status_set: assert property (@(posedge pclk) disable iff (!presetn)
    parity_fault |=> tx_cell_event_status[7])
    else $error("parity fault not latched");
  // cell start fault lands in status bit six
  a_start_fault_stat: assert property (@(posedge pclk) disable iff (!presetn)
    cell_start_fault |=> tx_cell_event_status[6])
    else $error("cell start fault not latched");
  // transmit fifo overrun lands in status bit five
  a_txfifo_status: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fifo_overrun |=> tx_cell_event_status[5])
    else $error("tx fifo overrun not latched");
  // receive fifo overrun lands in status bit four
  a_rxfifo_status: assert property (@(posedge pclk) disable iff (!presetn)
    rx_fifo_overrun |=> tx_cell_event_status[4])
    else $error("rx fifo overrun not latched");
  // a sent cell on a clear status bit pends when enabled
  a_cell_sent_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (cell_out_event && !tx_cell_event_status[3] && tx_irq_enable[3])
    |=> tx_cell_irq_pending[3])
    else $error("cell sent did not pend");
  // a status bit already high cannot raise a new indication
  a_no_rise_no_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (!tx_cell_irq_pending[6] && tx_cell_event_status[6] && !(rd_done && hit_txs))
    |=> !tx_cell_irq_pending[6])
    else $error("pending set without status rise");
  // the low transmit bits never carry an event
  a_tx_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_cell_event_status[2:0] == 3'h0) && (tx_cell_irq_pending[2:0] == 3'h0))
    else $error("reserved tx bit set");
  // a status read clears every bit it returned unless an event hits it
  a_status_read_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && hit_txs && !(|tx_evt)) |=> (tx_cell_event_status & prdata[7:0]) == 8'h00)
    else $error("tx status not cleared by read");

  // delineation change in either direction pends when enabled
  a_delin_dual: assert property (@(posedge pclk) disable iff (!presetn)
    ($changed(delin_loss_state) && rx_cell_irq_enable[7]) |=> rx_cell_irq_pending[7])
    else $error("delineation change not flagged");
  // an enabled single-event receive source pends at once
  a_rx_single_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (cell_in && rx_cell_irq_enable[3]) |=> rx_cell_irq_pending[3])
    else $error("cell received did not pend");
  // corrected header errors pend in bit five
  a_hdr_fix_pend: assert property (@(posedge pclk) disable iff (!presetn)
    (hdr_err_fix && rx_cell_irq_enable[5]) |=> rx_cell_irq_pending[5])
    else $error("corrected header error did not pend");
  // a disabled receive source stays quiet
  a_rx_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (flow_field_set && !rx_cell_irq_enable[0] && !rx_cell_irq_pending[0])
    |=> !rx_cell_irq_pending[0])
    else $error("disabled rx source pended");
  // the reserved receive indication never sets
  a_rx_reserved_pend: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_cell_irq_pending[4])
    else $error("reserved rx pending bit set");
  // a pending read clears the bits it returned unless an event hits them
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_done && hit_rxp && !(|rx_set)) |=> (rx_cell_irq_pending & prdata[7:0]) == 8'h00)
    else $error("rx pending not cleared by read");

  // ready answers the cycle after setup
  a_ready_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("ready missing after setup");
  // ready stands for one cycle only
  a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  // an unmapped word answers with an error
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !hit_any) |=> pslverr)
    else $error("unmapped access without error");

  // main scenarios
  c_pin_asserted: cover property (@(posedge pclk) disable iff (!presetn) $fell(host_irq_n));
  c_disabled_event: cover property (@(posedge pclk) disable iff (!presetn)
    flow_field_set && !rx_cell_irq_enable[0]);
  c_delin_regain: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(delin_loss_state) ##1 rx_cell_irq_pending[7]);
  c_set_on_read: cover property (@(posedge pclk) disable iff (!presetn)
    rd_done && hit_txp && (|tx_set));
  c_sys_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule

`default_nettype wire

// ---- common/celi_pkg.sv ----
// Purpose: shared constants for the cell event interrupt logic
// Assumes: 32-bit apb, byte address = 4 * register index
// Notes: indices are kept as printed; the bus decoder scales them
package celi_pkg;

  // ****************************************************************
  // register indices (byte address is index times four)
  // ****************************************************************
  localparam logic [7:0] IDX_TX_IRQ_ENABLE = 8'h28; // transmit source enables
  localparam logic [7:0] IDX_RX_IRQ_ENABLE = 8'h29; // rx_cell_irq_enable
  localparam logic [7:0] IDX_TX_PENDING = 8'h2C; // tx_cell_irq_pending
  localparam logic [7:0] IDX_RX_PENDING = 8'h2D; // rx_cell_irq_pending
  localparam logic [7:0] IDX_TX_STATUS = 8'h2E; // tx_cell_event_status
  localparam logic [7:0] IDX_IRQ_GATE = 8'h40; // summary, port and pin enables
  localparam logic [7:0] IDX_SYS_STATUS = 8'h41; // sticky system events, w1c
  localparam logic [7:0] IDX_SYS_MASK = 8'h42; // mask for the system irq

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_RX_IRQ_ENABLE = 8'hEF; // bit 4 reserved zero
  localparam logic [7:0] RST_TX_IRQ_ENABLE = 8'hFC; // bits 1:0 reserved zero
  localparam logic [3:0] RST_IRQ_GATE = 4'h0; // all gating off
  localparam logic [1:0] RST_SYS_MASK = 2'h0; // system irq masked

  // ****************************************************************
  // field layouts
  // ****************************************************************
  localparam logic [7:0] TX_USED_MASK = 8'hF8; // bits 7..3 carry events
  localparam logic [7:0] RX_USED_MASK = 8'hEF; // bit 4 reserved
  localparam int RX_DELIN_BIT = 7; // dual-event source
  localparam int GATE_RX_SUM = 0; // rx_cell_summary_enable
  localparam int GATE_TX_SUM = 1; // transmit summary enable
  localparam int GATE_PORT = 2; // port_irq_enable
  localparam int GATE_PIN = 3; // irq_pin_enable
  localparam int SYS_TX_EVT = 0; // a transmit pending bit was set
  localparam int SYS_RX_EVT = 1; // a receive pending bit was set

endpackage

// ---- sim/cell_event_interrupt_logic_tb_top.sv ----
// Purpose: self-checking bench for the cell event interrupt logic
// Assumes: apb answers with one access cycle; event inputs are one-cycle pulses
// Notes: reserved enable bits are always written as zero by this bench
`timescale 1ns/10ps
`default_nettype none
module cell_event_interrupt_logic_tb_top;
  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  logic pclk = 1'b0; // 40 mhz bus clock
  logic presetn = 1'b0; // async reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, host_irq_n, irq;
  logic [7:0] txv = 8'h00; // transmit events, bit n drives status bit n
  logic [7:0] rxv = 8'h00; // receive single events, same layout
  logic dl = 1'b0; // present delineation state
  logic [31:0] rd; // last read data
  logic er; // last error flag
  int mismatches = 0, checks = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  celi_cell_event_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .parity_fault(txv[7]), .cell_start_fault(txv[6]),
    .tx_fifo_overrun(txv[5]), .rx_fifo_overrun(txv[4]), .cell_out_event(txv[3]),
    .delin_loss_state(dl), .hdr_err_det(rxv[6]), .hdr_err_fix(rxv[5]), .cell_in(rxv[3]),
    .idle_in(rxv[2]), .screen_reject(rxv[1]), .flow_field_set(rxv[0]),
    .host_irq_n(host_irq_n), .irq(irq));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // one apb transfer; waits for pready, only the bench timeout ends a wait
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // compare and count; unknowns never match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one-cycle event pulses, then let the pending and pin stages settle
  task automatic pulse(input logic [7:0] t, input logic [7:0] r);
    @(posedge pclk);
    txv <= t;
    rxv <= r;
    @(posedge pclk);
    txv <= 8'h00;
    rxv <= 8'h00;
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    apb(1'b0, celi_pkg::IDX_RX_IRQ_ENABLE, 8'h00);
    chk(rd, 32'h0000_00EF, "rx enable reset");
    chk({31'h0, er}, 32'h0, "mapped no error");
    apb(1'b0, celi_pkg::IDX_TX_IRQ_ENABLE, 8'h00);
    chk(rd, 32'h0000_00FC, "tx enable reset");
    apb(1'b0, celi_pkg::IDX_TX_PENDING, 8'h00);
    chk(rd, 32'h0, "tx pending reset");
    apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
    chk(rd, 32'h0, "rx pending reset");
    apb(1'b0, 8'hFF, 8'h00);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset done");
  endtask
  // every transmit source: status, pending, pin, read-clear
  task automatic t_tx();
    apb(1'b1, celi_pkg::IDX_IRQ_GATE, 8'h0F);
    for (int i = 3; i < 8; i++)
    begin
      pulse(8'h01 << i, 8'h00);
      chk({31'h0, host_irq_n}, 32'h0, "pin low on tx");
      apb(1'b0, celi_pkg::IDX_TX_STATUS, 8'h00);
      chk(rd, 32'h1 << i, "tx status bit");
      chk({29'h0, rd[2:0]} & 32'h3, 32'h0, "tx status low bits");
      apb(1'b0, celi_pkg::IDX_TX_PENDING, 8'h00);
      chk(rd, 32'h1 << i, "tx pending bit");
      settle();
      chk({31'h0, host_irq_n}, 32'h1, "pin high after clear");
    end
    // status still set from an unread event: no new pending
    pulse(8'h80, 8'h00);
    apb(1'b0, celi_pkg::IDX_TX_PENDING, 8'h00);
    pulse(8'h80, 8'h00);
    apb(1'b0, celi_pkg::IDX_TX_PENDING, 8'h00);
    chk(rd, 32'h0, "no pend while status high");
    apb(1'b0, celi_pkg::IDX_TX_STATUS, 8'h00);
    chk(rd, 32'h80, "status latched both");
    apb(1'b0, celi_pkg::IDX_TX_STATUS, 8'h00);
    chk(rd, 32'h0, "status cleared by read");
    // disabled transmit source: status latches, no indication, pin quiet
    apb(1'b1, celi_pkg::IDX_TX_IRQ_ENABLE, 8'hF0);
    pulse(8'h08, 8'h00);
    chk({31'h0, host_irq_n}, 32'h1, "disabled tx quiet");
    apb(1'b0, celi_pkg::IDX_TX_PENDING, 8'h00);
    chk(rd, 32'h0, "disabled tx no pend");
    apb(1'b0, celi_pkg::IDX_TX_STATUS, 8'h00);
    chk(rd, 32'h08, "status set while disabled");
    apb(1'b1, celi_pkg::IDX_TX_IRQ_ENABLE, 8'hF8);
    $display("test tx done");
  endtask
  // receive single and dual events, enables and gating
  task automatic t_rx();
    for (int i = 0; i < 7; i++)
    begin
      if (i == 4)
        continue;
      pulse(8'h00, 8'h01 << i);
      chk({31'h0, host_irq_n}, 32'h0, "pin low on rx");
      apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
      chk(rd, 32'h1 << i, "rx pending bit");
      apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
      chk(rd, 32'h0, "rx read cleared");
    end
    dl <= 1'b1;
    settle();
    apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
    chk(rd, 32'h80, "delineation lost");
    dl <= 1'b0;
    settle();
    apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
    chk(rd, 32'h80, "delineation regained");
    // disabled source must not pend; reserved bit written as zero
    apb(1'b1, celi_pkg::IDX_RX_IRQ_ENABLE, 8'hEE);
    pulse(8'h00, 8'h01);
    chk({31'h0, host_irq_n}, 32'h1, "disabled stays quiet");
    apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
    chk(rd, 32'h0, "disabled no pend");
    // summary enable off: bit pends but pin stays high
    apb(1'b1, celi_pkg::IDX_IRQ_GATE, 8'h0E);
    pulse(8'h00, 8'h08);
    chk({31'h0, host_irq_n}, 32'h1, "summary gate off");
    apb(1'b1, celi_pkg::IDX_IRQ_GATE, 8'h07);
    settle();
    chk({31'h0, host_irq_n}, 32'h1, "pin enable off");
    apb(1'b1, celi_pkg::IDX_IRQ_GATE, 8'h0F);
    settle();
    chk({31'h0, host_irq_n}, 32'h0, "all four gates on");
    apb(1'b0, celi_pkg::IDX_RX_PENDING, 8'h00);
    chk(rd, 32'h08, "gated bit still pending");
    $display("test rx done");
  endtask
  // system status, mask and the level irq output
  task automatic t_sys();
    apb(1'b1, celi_pkg::IDX_SYS_STATUS, 8'h03);
    apb(1'b1, celi_pkg::IDX_SYS_MASK, 8'h03);
    settle();
    chk({31'h0, irq}, 32'h0, "irq idle");
    pulse(8'h08, 8'h00);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, celi_pkg::IDX_SYS_MASK, 8'h02);
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, celi_pkg::IDX_SYS_STATUS, 8'h01);
    apb(1'b1, celi_pkg::IDX_SYS_MASK, 8'h03);
    settle();
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test sys done");
  endtask
  // ****************************************************************
  // verdict, timeout and main sequence
  // ****************************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ceiling far above the few hundred cycles the tests need
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      test_done();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_sys();
    test_done();
  end
endmodule
`default_nettype wire
